/* core/timer2_capture_reload.sv */
// sixteen-bit timer with capture and auto-reload, byte registers on a
// plain strobe port; assumes trigger pin synchronous to clk at 40 MHz.
`include "timer2_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module timer2_capture_reload #(
	parameter int TICK_DIV = `T2_TICK_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdata,
	// external trigger
	input wire logic extTriggerPin,
	// interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	logic wrCtrl;
	logic wrMode;
	logic wrRcapL;
	logic wrRcapH;
	logic wrCntL;
	logic wrCntH;
	logic wrStat;
	logic wrMask;

	assign wrCtrl = wrStb && hit(addr, `T2_ADDR_CTRL);
	assign wrMode = wrStb && hit(addr, `T2_ADDR_MODE);
	assign wrRcapL = wrStb && hit(addr, `T2_ADDR_RCAPL);
	assign wrRcapH = wrStb && hit(addr, `T2_ADDR_RCAPH);
	assign wrCntL = wrStb && hit(addr, `T2_ADDR_CNTL);
	assign wrCntH = wrStb && hit(addr, `T2_ADDR_CNTH);
	assign wrStat = wrStb && hit(addr, `T2_ADDR_STAT);
	assign wrMask = wrStb && hit(addr, `T2_ADDR_MASK);

	////////////////////////////////////////////////////////////////////////
	// control and mode registers

	logic ovfFlag_r;
	logic extFlag_r;
	logic extEnable_r;
	logic run_r;
	logic capSel_r;
	logic downEn_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			extEnable_r <= 1'b0;
			run_r <= 1'b0;
			capSel_r <= 1'b0;
		end else if (wrCtrl) begin
			extEnable_r <= wdata[`T2_CTRL_EXTEN];
			run_r <= wdata[`T2_CTRL_RUN];
			capSel_r <= wdata[`T2_CTRL_CPSEL];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			downEn_r <= 1'b0;
		end else if (wrMode) begin
			downEn_r <= wdata[`T2_MODE_DOWN_COUNT_ENABLE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tick divider: one count step per machine cycle

	localparam int PW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_DIV - 1);

	logic [PW-1:0] pre_r;
	logic tick;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pre_r <= '0;
		end else if (!run_r || pre_r == PRE_LAST) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + PW'(1);
		end
	end

	assign tick = run_r && (pre_r == PRE_LAST);

	////////////////////////////////////////////////////////////////////////
	// trigger pin

	logic trigFall;
	logic trigEvent;

	fall_detect trigEdge (
		.clk(clk),
		.resetn(resetn),
		.pinLevel(extTriggerPin),
		.fall(trigFall)
	);

	assign trigEvent = trigFall && extEnable_r; // RULE_09

	////////////////////////////////////////////////////////////////////////
	// count path

	logic [7:0] rcapLo_r;
	logic [7:0] rcapHi_r;
	logic [7:0] cntLo_r;
	logic [7:0] cntHi_r;
	logic [15:0] count;
	logic [15:0] rcap;
	logic [15:0] count_nxt;
	logic downMode;
	logic overflowUp;
	logic underflowDown;
	logic reloadEv;
	logic captureEv;
	logic ovfEv;
	logic extEv;
	timer2_pkg::count_dir_type dir;

	assign count = {cntHi_r, cntLo_r};
	assign rcap = {rcapHi_r, rcapLo_r};

	// direction pin only matters in reload mode with down-count on
	assign downMode = downEn_r && !capSel_r; // RULE_01

	always_comb begin
		if (!tick) begin
			dir = timer2_pkg::CNT_HOLD; // RULE_11
		end else if (downMode && !extTriggerPin) begin
			dir = timer2_pkg::CNT_DOWN; // RULE_12
		end else begin
			dir = timer2_pkg::CNT_UP; // RULE_12
		end
	end

	assign overflowUp = (dir == timer2_pkg::CNT_UP) &&
		(count == `T2_COUNT_MAX);
	assign underflowDown = (dir == timer2_pkg::CNT_DOWN) && (count == rcap);
	// in down-count mode the pin steers direction, so edges do not reload
	// halted counter keeps its count, so edges reload only while running
	assign reloadEv = !capSel_r &&
		(overflowUp || (trigEvent && !downMode && run_r)); // RULE_10 RULE_11
	assign captureEv = capSel_r && trigEvent; // RULE_10
	assign ovfEv = overflowUp || underflowDown; // RULE_08
	assign extEv = trigEvent && !downMode;

	always_comb begin
		case (dir)
			timer2_pkg::CNT_HOLD: count_nxt = count;
			timer2_pkg::CNT_UP: count_nxt = count + 16'h0001; // RULE_07
			timer2_pkg::CNT_DOWN: count_nxt = count - 16'h0001;
			default: count_nxt = count;
		endcase
		if (underflowDown) begin
			count_nxt = `T2_DOWN_RELOAD;
		end
		if (reloadEv) begin
			count_nxt = rcap; // RULE_03 RULE_05
		end
	end

	// a software write to a count byte wins over counting in that cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cntLo_r <= `T2_RESET_BYTE;
		end else if (wrCntL) begin
			cntLo_r <= wdata; // RULE_06
		end else begin
			cntLo_r <= count_nxt[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cntHi_r <= `T2_RESET_BYTE;
		end else if (wrCntH) begin
			cntHi_r <= wdata; // RULE_07
		end else begin
			cntHi_r <= count_nxt[15:8];
		end
	end

	// hardware capture wins over a software write so no capture is lost
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rcapLo_r <= `T2_RESET_BYTE;
			rcapHi_r <= `T2_RESET_BYTE;
		end else if (captureEv) begin
			rcapLo_r <= cntLo_r; // RULE_02
			rcapHi_r <= cntHi_r; // RULE_04
		end else begin
			if (wrRcapL) begin
				rcapLo_r <= wdata;
			end
			if (wrRcapH) begin
				rcapHi_r <= wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flags: hardware set beats software clear

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ovfFlag_r <= 1'b0;
		end else begin
			ovfFlag_r <= ovfEv || (wrCtrl ? wdata[`T2_CTRL_OVF] : ovfFlag_r);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			extFlag_r <= 1'b0;
		end else begin
			extFlag_r <= extEv ||
				(wrCtrl ? wdata[`T2_CTRL_EXTF] : extFlag_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt

	logic [`T2_EV_WIDTH-1:0] evVec;
	logic [`T2_EV_WIDTH-1:0] statVal;
	logic [`T2_EV_WIDTH-1:0] maskVal;

	always_comb begin
		evVec = '0;
		evVec[`T2_EV_OVF] = ovfEv;
		evVec[`T2_EV_EXT] = extEv;
	end

	irq_status #(
		.WIDTH(`T2_EV_WIDTH)
	) irqUnit (
		.clk(clk),
		.resetn(resetn),
		.events(evVec),
		.statWrite(wrStat),
		.maskWrite(wrMask),
		.wdata(wdata[`T2_EV_WIDTH-1:0]),
		.status(statVal),
		.mask(maskVal),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////
	// read port: data valid only in the cycle after the strobe

	logic [7:0] rdata_r;
	logic [7:0] ctrlVal;

	always_comb begin
		ctrlVal = 8'h00;
		ctrlVal[`T2_CTRL_OVF] = ovfFlag_r;
		ctrlVal[`T2_CTRL_EXTF] = extFlag_r;
		ctrlVal[`T2_CTRL_EXTEN] = extEnable_r;
		ctrlVal[`T2_CTRL_RUN] = run_r;
		ctrlVal[`T2_CTRL_CPSEL] = capSel_r;
	end

	always_ff @(posedge clk) begin
		if (!resetn || !rdStb) begin
			rdata_r <= 8'h00;
		end else begin
			case (addr)
				`T2_ADDR_CTRL: rdata_r <= ctrlVal;
				`T2_ADDR_MODE: rdata_r <= {7'h00, downEn_r};
				`T2_ADDR_RCAPL: rdata_r <= rcapLo_r;
				`T2_ADDR_RCAPH: rdata_r <= rcapHi_r;
				`T2_ADDR_CNTL: rdata_r <= cntLo_r; // RULE_06
				`T2_ADDR_CNTH: rdata_r <= cntHi_r; // RULE_07
				`T2_ADDR_STAT: rdata_r <= {6'h00, statVal};
				`T2_ADDR_MASK: rdata_r <= {6'h00, maskVal};
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	assign rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	logic cntWrite;
	assign cntWrite = wrCntL || wrCntH;

	capture_low_a: assert property ( // RULE_02
		captureEv |=> rcapLo_r == $past(cntLo_r)
	) else $error("low capture byte not latched");

	capture_high_a: assert property ( // RULE_04
		captureEv |=> rcapHi_r == $past(cntHi_r) &&
			rcapLo_r == $past(cntLo_r)
	) else $error("high capture byte not latched");

	reload_low_a: assert property ( // RULE_03
		reloadEv && !wrCntL |=> cntLo_r == $past(rcapLo_r)
	) else $error("reload low byte wrong");

	reload_high_a: assert property ( // RULE_05
		reloadEv && !wrCntH |=> cntHi_r == $past(rcapHi_r)
	) else $error("reload high byte wrong");

	low_read_a: assert property ( // RULE_06
		rdStb && addr == `T2_ADDR_CNTL |=> rdata == $past(cntLo_r)
	) else $error("low count read wrong");

	carry_high_a: assert property ( // RULE_07
		dir == timer2_pkg::CNT_UP && count == 16'h00ff && !cntWrite &&
			!reloadEv
		|=> count == 16'h0100
	) else $error("carry into high byte missing");

	flag_set_a: assert property ( // RULE_08
		ovfEv |=> ovfFlag_r ##1 (ovfFlag_r || $past(wrCtrl))
	) else $error("overflow flag not set");

	pin_ignored_a: assert property ( // RULE_09
		!extEnable_r && !wrRcapL && !wrRcapH |-> !extEv ##1 $stable(rcap)
	) else $error("trigger acted while disabled");

	capture_select_a: assert property ( // RULE_10
		capSel_r && overflowUp && !cntWrite |=> count == 16'h0000
	) else $error("capture mode reloaded on overflow");

	halt_hold_a: assert property ( // RULE_11
		!run_r && !cntWrite |=> $stable(count)
	) else $error("count moved while halted");

	down_step_a: assert property ( // RULE_12
		dir == timer2_pkg::CNT_DOWN && !underflowDown && !cntWrite
		|=> count == $past(count) - 16'h0001
	) else $error("down count step wrong");

	direction_a: assert property ( // RULE_01
		tick && (!downMode || extTriggerPin) |-> dir == timer2_pkg::CNT_UP
	) else $error("direction wrong");

endmodule

`default_nettype wire

/* core/timer2_consts.svh */
// constants of the timer 2 capture and reload block: offsets, fields,
// reset values and timing counts; assumes a byte-wide register port.
//
// Notes on behaviour
// RULE_01: mode bit 0 and trigger pin level set direction in reload mode.
// RULE_02: capture event copies the low count byte into low capture register.
// RULE_03: low capture register gives the reload value's low byte.
// RULE_04: same capture event copies the high count byte into high register.
// RULE_05: high capture register gives the reload value's high byte.
// RULE_06: software reads and writes the low count byte.
// RULE_07: software reads and writes the high count byte, carried from low.
// RULE_08: overflow, or down-count match with capture value, sets the flag.
// RULE_09: trigger falling edge acts only with external enable set.
// RULE_10: select 0 reloads on overflow or edge; select 1 captures on edge. Edge reload here needs run set and down-count off.
// RULE_11: clearing run halts counter and keeps its sixteen-bit count.
// RULE_12: down-count mode counts up while pin high, down while low.
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// register offsets
`define T2_ADDR_CTRL 8'hc8
`define T2_ADDR_MODE 8'hc9
`define T2_ADDR_RCAPL 8'hca
`define T2_ADDR_RCAPH 8'hcb
`define T2_ADDR_CNTL 8'hcc
`define T2_ADDR_CNTH 8'hcd
`define T2_ADDR_STAT 8'hce
`define T2_ADDR_MASK 8'hcf

// control register fields
`define T2_CTRL_OVF 7
`define T2_CTRL_EXTF 6
`define T2_CTRL_EXTEN 3
`define T2_CTRL_RUN 2
`define T2_CTRL_CPSEL 0
// mode register field
`define T2_MODE_DOWN_COUNT_ENABLE 0

// interrupt status and mask fields
`define T2_EV_OVF 0
`define T2_EV_EXT 1
`define T2_EV_WIDTH 2

// reset, underflow reload and count limit values
`define T2_RESET_BYTE 8'h00
`define T2_DOWN_RELOAD 16'hffff
`define T2_COUNT_MAX 16'hffff

// core clocks per count tick
`define T2_TICK_DIV 12

`endif

/* core/timer2_pkg.sv */
// types shared by the timer 2 capture and reload block.
// assumes the constants header is included by the design files.
package timer2_pkg;

	// direction the counter takes in the current cycle
	typedef enum logic [1:0] {
		CNT_HOLD = 2'b00,
		CNT_UP = 2'b01,
		CNT_DOWN = 2'b10
	} count_dir_type;

endpackage

/* core/fall_detect.sv */
// falling edge detector for the external trigger pin.
// assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module fall_detect (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// pin and edge
	input wire logic pinLevel,
	output logic fall
);

	logic prev_r;

	// idles high so a pin held low out of reset gives an edge in the first cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			prev_r <= 1'b1;
		end else begin
			prev_r <= pinLevel;
		end
	end

	assign fall = prev_r && !pinLevel;

endmodule

`default_nettype wire

/* core/irq_status.sv */
// sticky event status, write-one-to-clear, with mask and level interrupt.
// assumes write strobes are single-cycle and already decoded.
`timescale 1ns/1ps
`default_nettype none

module irq_status #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// events and software access
	input wire logic [WIDTH-1:0] events,
	input wire logic statWrite,
	input wire logic maskWrite,
	input wire logic [WIDTH-1:0] wdata,
	// state and interrupt
	output logic [WIDTH-1:0] status,
	output logic [WIDTH-1:0] mask,
	output logic irq
);

	logic [WIDTH-1:0] status_r;
	logic [WIDTH-1:0] mask_r;
	logic [WIDTH-1:0] status_nxt;
	logic irq_r;

	// a new event beats a clear in the same cycle
	always_comb begin
		status_nxt = status_r;
		if (statWrite) begin
			status_nxt = status_r & ~wdata;
		end
		status_nxt = status_nxt | events;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mask_r <= '0;
		end else if (maskWrite) begin
			mask_r <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(status_nxt & mask_r);
		end
	end

	assign status = status_r;
	assign mask = mask_r;
	assign irq = irq_r;

endmodule

`default_nettype wire

/* testbench/trigger_model.sv */
// far-side source of the external trigger pin: idles high, pulses low
// or holds low on request; assumes requests change just after clk rises
`timescale 1ns/1ps
`default_nettype none

module trigger_model #(
	parameter int LOW_CYCLES = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// requests from the bench
	input wire logic pulseReq,
	input wire logic holdLow,
	// pin
	output logic pinOut
);
	int lowLeft;

	////////////////////////////////////////////////////////////////////
	// idle high across reset, so reset itself never reads as an edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lowLeft <= 0;
			pinOut <= 1'b1;
		end else begin
			if (pulseReq)
				lowLeft <= LOW_CYCLES;
			else if (lowLeft > 0)
				lowLeft <= lowLeft - 1;
			pinOut <= !(holdLow || pulseReq || lowLeft > 1);
		end
	end
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the timer 2 capture and reload block
// assumes the design sources and the trigger model are compiled first
`include "timer2_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// slow prescaler keeps the count still for a whole scenario step
	localparam int TD = 64;
	localparam logic [7:0] RUN = 8'h01 << `T2_CTRL_RUN;
	localparam logic [7:0] EXEN = 8'h01 << `T2_CTRL_EXTEN;
	localparam logic [7:0] CPSEL = 8'h01 << `T2_CTRL_CPSEL;
	localparam logic [7:0] OVF = 8'h01 << `T2_CTRL_OVF;
	localparam logic [7:0] EXTF = 8'h01 << `T2_CTRL_EXTF;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic [7:0] rdata;
	logic pin;
	logic irq;
	logic pulseReq = 1'b0;
	logic holdLow = 1'b0;
	int failCount = 0;
	int comparisons = 0;

	always #12.5 clk = ~clk;

	timer2_capture_reload #(.TICK_DIV(TD)) i_timer2_capture_reload (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
		.extTriggerPin(pin), .irq(irq));
	trigger_model i_trigger_model (.clk(clk), .resetn(resetn),
		.pulseReq(pulseReq), .holdLow(holdLow), .pinOut(pin));

	////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (failCount == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failCount++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 8'h01, d[15:8]);
	endtask

	task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
		rd(a, exp[7:0]);
		rd(a + 8'h01, exp[15:8]);
	endtask

	task automatic pulse();
		@(posedge clk);
		pulseReq <= 1'b1;
		@(posedge clk);
		pulseReq <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		stop_test();
	end

	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		for (int a = 8'hc8; a <= 8'hcf; a++)
			rd(8'(a), `T2_RESET_BYTE);
		wr(8'hd0, 8'hff);
		rd(8'hd0, 8'h00);
		// software access with the counter halted
		wr16(`T2_ADDR_CNTL, 16'ha55a);
		repeat (100) @(posedge clk);
		rd16(`T2_ADDR_CNTL, 16'ha55a);
		// capture on an enabled falling edge, before the first step
		wr16(`T2_ADDR_CNTL, 16'habcd);
		wr(`T2_ADDR_CTRL, EXEN | CPSEL | RUN);
		pulse();
		rd(`T2_ADDR_CTRL, EXTF | EXEN | CPSEL | RUN);
		wr(`T2_ADDR_CTRL, 8'h00);
		rd(`T2_ADDR_RCAPL, 8'hcd);
		rd(`T2_ADDR_RCAPH, 8'hab);
		rd(`T2_ADDR_STAT, 8'h02);
		wr(`T2_ADDR_STAT, 8'h02);
		// edge with the external enable clear changes nothing
		wr16(`T2_ADDR_CNTL, 16'h1111);
		wr(`T2_ADDR_CTRL, CPSEL | RUN);
		pulse();
		rd(`T2_ADDR_CTRL, CPSEL | RUN);
		wr(`T2_ADDR_CTRL, 8'h00);
		rd16(`T2_ADDR_RCAPL, 16'habcd);
		rd(`T2_ADDR_STAT, 8'h00);
		// reload on overflow, flag and interrupt path
		wr16(`T2_ADDR_RCAPL, 16'h1234);
		wr16(`T2_ADDR_CNTL, 16'hffff);
		wr(`T2_ADDR_CTRL, RUN);
		repeat (TD + 4) @(posedge clk);
		rd16(`T2_ADDR_CNTL, 16'h1234);
		rd(`T2_ADDR_CTRL, OVF | RUN);
		rd(`T2_ADDR_STAT, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wr(`T2_ADDR_MASK, 8'h01);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h01);
		wr(`T2_ADDR_STAT, 8'h01);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		rd(`T2_ADDR_STAT, 8'h00);
		wr(`T2_ADDR_CTRL, 8'h00);
		// reload forced by an enabled trigger edge
		wr16(`T2_ADDR_CNTL, 16'h0042);
		wr(`T2_ADDR_CTRL, EXEN | RUN);
		pulse();
		wr(`T2_ADDR_CTRL, 8'h00);
		rd16(`T2_ADDR_CNTL, 16'h1234);
		// down count with pin low: match with capture value gives ffff
		wr(`T2_ADDR_MODE, 8'h01);
		rd(`T2_ADDR_MODE, 8'h01);
		wr16(`T2_ADDR_RCAPL, 16'h0010);
		wr16(`T2_ADDR_CNTL, 16'h0011);
		holdLow <= 1'b1;
		repeat (4) @(posedge clk);
		wr(`T2_ADDR_CTRL, RUN);
		repeat (2 * TD + 16) @(posedge clk);
		rd(`T2_ADDR_CTRL, OVF | RUN);
		wr(`T2_ADDR_CTRL, 8'h00);
		rd16(`T2_ADDR_CNTL, 16'hffff);
		// pin high in down-count mode counts up, carrying into high byte
		@(posedge clk);
		holdLow <= 1'b0;
		wr16(`T2_ADDR_CNTL, 16'h00ff);
		wr(`T2_ADDR_CTRL, RUN);
		repeat (TD + 8) @(posedge clk);
		wr(`T2_ADDR_CTRL, 8'h00);
		rd16(`T2_ADDR_CNTL, 16'h0100);
		// capture mode wraps to zero on overflow and still flags it
		wr16(`T2_ADDR_CNTL, 16'hffff);
		wr(`T2_ADDR_CTRL, CPSEL | RUN);
		repeat (TD + 8) @(posedge clk);
		rd(`T2_ADDR_CTRL, OVF | CPSEL | RUN);
		wr(`T2_ADDR_CTRL, 8'h00);
		rd16(`T2_ADDR_CNTL, 16'h0000);
		stop_test();
	end
endmodule

`default_nettype wire
